// File: rtl/ppi_top.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) Tx PLCP data-enable out and data pins invert when bits 15/14 set.
// (RULE_02) Tx multifunction start-of-frame output pin inverts when bit 12 set.
// (RULE_03) Tx overhead-enable input pin inverts when bit 11 set.
// (RULE_04) Tx overhead/serial data pin inverts when bit 10 set.
// (RULE_05) Tx overhead port sof, enable, data, clock invert by bits 9..6.
// (RULE_06) Tx start-of-frame input / mask pin inverts when bit 5 set.
// (RULE_07) Tx negative and positive rail pins invert by bits 4 and 3.
// (RULE_08) Tx line clock, clock out, clock in invert by bits 2..0.
// (RULE_09) Rx PLCP data and overhead-enable input invert by bits 14, 13.
// (RULE_10) Rx multifunction start-of-frame output inverts when bit 12 set.
// (RULE_11) Rx overhead/serial data pin inverts when bit 10 set.
// (RULE_12) Rx overhead port sof, data, clock invert by bits 9, 7, 6.
// (RULE_13) Rx negative and positive rail inputs invert by bits 4 and 3.
// (RULE_14) Rx line clock and clock output invert by bits 2 and 1.
// (RULE_15) Port status summary set by any enabled latched port status bit.
// (RULE_16) Line code summary set by any enabled latched line coder bit.
// (RULE_17) Trail trace and far-end alarm summaries from their enabled latched bits.
// (RULE_18) HDLC and bit error test summaries from their enabled latched bits.
// (RULE_19) FIFO summary from enabled latched bits of tx or rx FIFO.
// (RULE_20) Cell/packet and PLCP summaries from their enabled latched bits.
// (RULE_21) Interrupt pin driven when any summary set and port enable set.
// (RULE_22) All invert controls reset to zero.
// (RULE_23) Summaries are read-only ORs, clearing when sources clear or disable.
module ppi_top
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] tx_pin_in,
	output logic [15:0] tx_pin_out,
	input wire logic [15:0] rx_pin_in,
	output logic [15:0] rx_pin_out,
	input wire logic [15:0] port_latched_status,
	input wire logic [15:0] port_latched_enable,
	input wire logic [15:0] line_code_latched,
	input wire logic [15:0] line_code_enable,
	input wire logic [15:0] trail_trace_latched,
	input wire logic [15:0] trail_trace_enable,
	input wire logic [15:0] far_end_alarm_latched,
	input wire logic [15:0] far_end_alarm_enable,
	input wire logic [15:0] hdlc_latched,
	input wire logic [15:0] hdlc_enable,
	input wire logic [15:0] bit_error_test_latched,
	input wire logic [15:0] bit_error_test_enable,
	input wire logic [15:0] tx_fifo_latched,
	input wire logic [15:0] tx_fifo_enable,
	input wire logic [15:0] rx_fifo_latched,
	input wire logic [15:0] rx_fifo_enable,
	input wire logic [15:0] cell_packet_latched,
	input wire logic [15:0] cell_packet_enable,
	input wire logic [15:0] plcp_latched,
	input wire logic [15:0] plcp_enable,
	input wire logic framer_summary,
	input wire logic per_port_irq_enable,
	output logic irq_out
);
	logic [15:0] tx_inv_ff;
	logic [15:0] rx_inv_ff;
	logic [15:0] tx_sync1_ff;
	logic [15:0] tx_sync2_ff;
	logic [15:0] rx_sync1_ff;
	logic [15:0] rx_sync2_ff;
	logic [15:0] tx_inv_pins;
	logic [15:0] rx_inv_pins;
	logic [15:0] summary;
	logic [ppi_pkg::N_SUM-1:0] src_sum;
	logic [15:0] fifo_sum_src;
	logic [31:0] nxt_prdata;
	logic [15:0] lat_src [9];
	logic [15:0] en_src [9];
	logic wr_acc;
	logic rd_acc;
	logic [9:0] reg_addr;
	logic addr_hit;

	assign reg_addr = paddr[9:0];
	assign addr_hit = (paddr[31:10] == 22'h00_0000) && (reg_addr == ppi_pkg::TX_INV_ADDR
		|| reg_addr == ppi_pkg::RX_INV_ADDR || reg_addr == ppi_pkg::IRQ_SUM_ADDR);
	assign wr_acc = psel && penable && pwrite && clk_en;
	assign rd_acc = psel && penable && !pwrite && clk_en;

	// Invert control registers, byte lanes honoured
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_inv_ff <= ppi_pkg::INV_RST; // RULE_22
			rx_inv_ff <= ppi_pkg::INV_RST; // RULE_22
		end
		else if (wr_acc && paddr[31:10] == 22'h00_0000)
		begin
			if (reg_addr == ppi_pkg::TX_INV_ADDR)
			begin
				if (pstrb[0])
					tx_inv_ff[7:0] <= pwdata[7:0] & ppi_pkg::TX_INV_MASK[7:0];
				if (pstrb[1])
					tx_inv_ff[15:8] <= pwdata[15:8] & ppi_pkg::TX_INV_MASK[15:8];
			end
			else if (reg_addr == ppi_pkg::RX_INV_ADDR)
			begin
				if (pstrb[0])
					rx_inv_ff[7:0] <= pwdata[7:0] & ppi_pkg::RX_INV_MASK[7:0];
				if (pstrb[1])
					rx_inv_ff[15:8] <= pwdata[15:8] & ppi_pkg::RX_INV_MASK[15:8];
			end
		end
	end

	// Pin inputs pass two flip-flops
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_sync1_ff <= 16'h0000;
			tx_sync2_ff <= 16'h0000;
			rx_sync1_ff <= 16'h0000;
			rx_sync2_ff <= 16'h0000;
		end
		else if (clk_en)
		begin
			tx_sync1_ff <= tx_pin_in;
			tx_sync2_ff <= tx_sync1_ff;
			rx_sync1_ff <= rx_pin_in;
			rx_sync2_ff <= rx_sync1_ff;
		end
	end

	// Bit map equals register layout: bit n of pins follows invert bit n
	ppi_pin_invert u_tx_inv
	(
		.pin_in(tx_sync2_ff),
		.inv_ctl(tx_inv_ff),
		.pin_out(tx_inv_pins)
	);

	ppi_pin_invert u_rx_inv
	(
		.pin_in(rx_sync2_ff),
		.inv_ctl(rx_inv_ff),
		.pin_out(rx_inv_pins)
	);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_pin_out <= 16'h0000;
			rx_pin_out <= 16'h0000;
		end
		else if (clk_en)
		begin
			tx_pin_out <= tx_inv_pins; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_08
			rx_pin_out <= rx_inv_pins; // RULE_09 RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
		end
	end

	// Sub-block latched status comes from same-clock logic; no sync needed
	assign fifo_sum_src = 16'h0000;
	assign lat_src[0] = port_latched_status;
	assign lat_src[1] = line_code_latched;
	assign lat_src[2] = trail_trace_latched;
	assign lat_src[3] = far_end_alarm_latched;
	assign lat_src[4] = hdlc_latched;
	assign lat_src[5] = bit_error_test_latched;
	assign lat_src[6] = cell_packet_latched;
	assign lat_src[7] = plcp_latched;
	assign lat_src[8] = fifo_sum_src;
	assign en_src[0] = port_latched_enable;
	assign en_src[1] = line_code_enable;
	assign en_src[2] = trail_trace_enable;
	assign en_src[3] = far_end_alarm_enable;
	assign en_src[4] = hdlc_enable;
	assign en_src[5] = bit_error_test_enable;
	assign en_src[6] = cell_packet_enable;
	assign en_src[7] = plcp_enable;
	assign en_src[8] = fifo_sum_src;

	logic [8:0] grp_sum;
	logic fifo_tx_sum;
	logic fifo_rx_sum;

	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_sum
			ppi_sum_or u_or
			(
				.latched(lat_src[g]),
				.enable(en_src[g]),
				.summary(grp_sum[g])
			);
		end
	endgenerate
	assign grp_sum[8] = 1'b0;

	// Either FIFO direction feeds the one FIFO summary bit
	ppi_sum_or u_fifo_tx_or
	(
		.latched(tx_fifo_latched),
		.enable(tx_fifo_enable),
		.summary(fifo_tx_sum)
	);

	ppi_sum_or u_fifo_rx_or
	(
		.latched(rx_fifo_latched),
		.enable(rx_fifo_enable),
		.summary(fifo_rx_sum)
	);

	assign src_sum[ppi_pkg::SUM_PORT] = grp_sum[0]; // RULE_15
	assign src_sum[ppi_pkg::SUM_LCODE] = grp_sum[1]; // RULE_16
	assign src_sum[ppi_pkg::SUM_TRACE] = grp_sum[2]; // RULE_17
	assign src_sum[ppi_pkg::SUM_FEAC] = grp_sum[3]; // RULE_17
	assign src_sum[ppi_pkg::SUM_HDLC] = grp_sum[4]; // RULE_18
	assign src_sum[ppi_pkg::SUM_BERT] = grp_sum[5]; // RULE_18
	assign src_sum[ppi_pkg::SUM_FIFO] = fifo_tx_sum | fifo_rx_sum; // RULE_19
	assign src_sum[ppi_pkg::SUM_CELL_PKT] = grp_sum[6]; // RULE_20
	assign src_sum[ppi_pkg::SUM_PLCP] = grp_sum[7]; // RULE_20
	assign src_sum[ppi_pkg::SUM_FRAMER] = framer_summary;

	// Read-only, no latching of its own
	assign summary = {6'h00, src_sum}; // RULE_23

	always_comb
	begin
		nxt_prdata = 32'h0000_0000;
		if (reg_addr == ppi_pkg::TX_INV_ADDR)
			nxt_prdata = {16'h0000, tx_inv_ff};
		else if (reg_addr == ppi_pkg::RX_INV_ADDR)
			nxt_prdata = {16'h0000, rx_inv_ff};
		else if (reg_addr == ppi_pkg::IRQ_SUM_ADDR)
			nxt_prdata = {16'h0000, summary};
		if (!addr_hit)
			nxt_prdata = 32'h0000_0000;
	end

	// Zero-wait APB slave while clk_en is high: pready registered high only in the access cycle after each setup cycle (psel && !penable)
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_hit;
			if (psel && !penable && !pwrite)
				prdata <= nxt_prdata;
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_out <= 1'b0;
		end
		else if (clk_en)
		begin
			// Enable comes from same-clock logic; used without sync
			irq_out <= (|summary) && per_port_irq_enable; // RULE_21
		end
	end
endmodule

// File: rtl/ppi_pkg.sv
package ppi_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned REG_W = 16;
	// Printed offsets are word indices; byte address is four times the index
	localparam logic [7:0] TX_INV_IDX = 8'h4a;
	localparam logic [7:0] RX_INV_IDX = 8'h4c;
	localparam logic [7:0] IRQ_SUM_IDX = 8'h50;
	localparam logic [9:0] TX_INV_ADDR = {TX_INV_IDX, 2'b00};
	localparam logic [9:0] RX_INV_ADDR = {RX_INV_IDX, 2'b00};
	localparam logic [9:0] IRQ_SUM_ADDR = {IRQ_SUM_IDX, 2'b00};
	// Implemented bits of each invert register
	localparam logic [15:0] TX_INV_MASK = 16'hdfff;
	localparam logic [15:0] RX_INV_MASK = 16'h76de;
	localparam logic [15:0] INV_RST = 16'h0000;
	localparam int unsigned N_SUM = 10;
	// Summary bit positions
	localparam int unsigned SUM_FRAMER = 0;
	localparam int unsigned SUM_PLCP = 1;
	localparam int unsigned SUM_CELL_PKT = 2;
	localparam int unsigned SUM_FIFO = 3;
	localparam int unsigned SUM_BERT = 4;
	localparam int unsigned SUM_HDLC = 5;
	localparam int unsigned SUM_FEAC = 6;
	localparam int unsigned SUM_TRACE = 7;
	localparam int unsigned SUM_LCODE = 8;
	localparam int unsigned SUM_PORT = 9;
endpackage

// File: rtl/ppi_pin_invert.sv
`timescale 1ns/1ps
module ppi_pin_invert
(
	input wire logic [15:0] pin_in,
	input wire logic [15:0] inv_ctl,
	output logic [15:0] pin_out
);
	genvar i;
	generate
		for (i = 0; i < 16; i++)
		begin : g_bit
			assign pin_out[i] = pin_in[i] ^ inv_ctl[i];
		end
	endgenerate
endmodule

// File: rtl/ppi_sum_or.sv
`timescale 1ns/1ps
module ppi_sum_or
(
	input wire logic [15:0] latched,
	input wire logic [15:0] enable,
	output logic summary
);
	assign summary = |(latched & enable);
endmodule

// File: dv/ppi_properties.sv
`timescale 1ns/1ps
module ppi_properties
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic framer_summary,
	input wire logic per_port_irq_enable,
	input wire logic irq_out
);
	logic hit;
	assign hit = paddr[31:10] == 0 && paddr[9:0] inside {ppi_pkg::TX_INV_ADDR,
		ppi_pkg::RX_INV_ADDR, ppi_pkg::IRQ_SUM_ADDR};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
	a_err_unmapped: assert property (pready && !hit |-> pslverr) else $error("no slverr");
	a_ok_mapped: assert property (pready && hit |-> !pslverr) else $error("false slverr");
	a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 0) else $error("data");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 0) else $error("upper");
	a_irq_masked: assert property (!per_port_irq_enable |=> !irq_out) else $error("irq");
	a_irq_framer: assert property (framer_summary && per_port_irq_enable |=> irq_out)
		else $error("irq missing");
	c_err: cover property (pready && pslverr);
	c_irq: cover property (irq_out);
	c_write: cover property (pready && pwrite);
endmodule
bind ppi_top ppi_properties ppi_properties_i (.*);

// File: dv/ppi_host.sv
`timescale 1ns/1ps
module ppi_host
(
	input wire logic core_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		{psel, penable, pwrite} = 3'b000;
		{paddr, pwdata} = 64'h0000_0000_0000_0000;
		pstrb = 4'hf;
	end
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		{psel, penable, pwrite} <= {2'b10, w};
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
endmodule

// File: dv/port_pin_polarity_irq_summary_tb.sv
`timescale 1ns/1ps
module port_pin_polarity_irq_summary_tb;
	logic core_clk, rstn, clk_en, psel, penable, pwrite, pready, pslverr, e;
	logic framer_summary, per_port_irq_enable, irq_out;
	logic [31:0] paddr, pwdata, prdata, r;
	logic [3:0] pstrb;
	logic [15:0] tx_pin_in, tx_pin_out, rx_pin_in, rx_pin_out, x, y;
	logic [15:0] lat [10];
	logic [15:0] ena [10];
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	localparam logic [31:0] TX = 32'(ppi_pkg::TX_INV_ADDR);
	localparam logic [31:0] RX = 32'(ppi_pkg::RX_INV_ADDR);
	localparam logic [31:0] SUM = 32'(ppi_pkg::IRQ_SUM_ADDR);
	ppi_host ppi_host_i (.*);
	ppi_top ppi_top_i (.*, .port_latched_status(lat[0]), .port_latched_enable(ena[0]),
		.line_code_latched(lat[1]), .line_code_enable(ena[1]), .trail_trace_latched(lat[2]),
		.trail_trace_enable(ena[2]), .far_end_alarm_latched(lat[3]),
		.far_end_alarm_enable(ena[3]), .hdlc_latched(lat[4]), .hdlc_enable(ena[4]),
		.bit_error_test_latched(lat[5]), .bit_error_test_enable(ena[5]),
		.tx_fifo_latched(lat[6]), .tx_fifo_enable(ena[6]), .rx_fifo_latched(lat[7]),
		.rx_fifo_enable(ena[7]), .cell_packet_latched(lat[8]), .cell_packet_enable(ena[8]),
		.plcp_latched(lat[9]), .plcp_enable(ena[9]));
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [15:0] v, input logic [15:0] g);
		n_compared++;
		if (g !== v)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, v, g);
		end
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		ppi_host_i.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [31:0] a);
		ppi_host_i.xfer(1'b0, a, 32'h0000_0000, r, e);
	endtask
	function automatic int pos(input int g);
		return g < 6 ? 9 - g : (g < 8 ? 3 : 10 - g);
	endfunction
	task automatic t_regs();
		rd(TX);
		chk("tx_inv", 16'h0000, r[15:0]);
		rd(RX);
		chk("rx_inv", 16'h0000, r[15:0]);
		wr(TX, 32'hffff_ffff);
		wr(RX, 32'hffff_ffff);
		rd(TX);
		chk("tx_inv", 16'hdfff, r[15:0]);
		rd(RX);
		chk("rx_inv", 16'h76de, r[15:0]);
		wr(SUM, 32'hffff_ffff);
		rd(SUM);
		chk("summary", 16'h0000, r[15:0]);
		rd(SUM + 32'h0000_0004);
		chk("slverr", 16'h0001, {15'h0000, e});
		$display("t_regs done");
	endtask
	task automatic t_pins();
		tx_pin_in <= 16'ha5a5;
		rx_pin_in <= 16'h3c3c;
		for (int b = 0; b < 16; b++)
		begin
			x = 16'h0001 << b;
			wr(TX, {16'h0000, x});
			wr(RX, {16'h0000, x});
			repeat (4) @(posedge core_clk);
			y = 16'ha5a5 ^ x & 16'hdfff;
			chk("tx", y, tx_pin_out);
			y = 16'h3c3c ^ x & 16'h76de;
			chk("rx", y, rx_pin_out);
		end
		$display("t_pins done");
	endtask
	task automatic t_sum();
		per_port_irq_enable <= 1'b1;
		for (int g = 0; g < 10; g++)
		begin
			x = 16'h0001 << g;
			lat[g] <= x;
			ena[g] <= ~x;
			rd(SUM);
			chk("sum_off", 16'h0000, r[15:0]);
			ena[g] <= x;
			rd(SUM);
			y = 16'h0001 << pos(g);
			chk("sum_on", y, r[15:0]);
			chk("irq_on", 16'h0001, {15'h0000, irq_out});
			per_port_irq_enable <= 1'b0;
			repeat (2) @(posedge core_clk);
			chk("irq_off", 16'h0000, {15'h0000, irq_out});
			per_port_irq_enable <= 1'b1;
			lat[g] <= 16'h0000;
			rd(SUM);
			chk("sum_clr", 16'h0000, r[15:0]);
		end
		framer_summary <= 1'b1;
		rd(SUM);
		chk("sum_framer", 16'h0001, r[15:0]);
		framer_summary <= 1'b0;
		$display("t_sum done");
	endtask
	task automatic t_hold();
		wr(TX, 32'h0000_0001);
		tx_pin_in <= 16'h0000;
		repeat (4) @(posedge core_clk);
		chk("hold_base", 16'h0001, tx_pin_out);
		clk_en <= 1'b0;
		tx_pin_in <= 16'h00f0;
		repeat (4) @(posedge core_clk);
		chk("hold_frozen", 16'h0001, tx_pin_out);
		clk_en <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("hold_run", 16'h00f1, tx_pin_out);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("rst_pins", 16'h0000, tx_pin_out);
		rstn <= 1'b1;
		rd(TX);
		chk("tx_inv_rst", 16'h0000, r[15:0]);
		$display("t_hold done");
	endtask
	initial
	begin
		{clk_en, rstn, framer_summary, per_port_irq_enable} = 4'b1000;
		{tx_pin_in, rx_pin_in} = 32'h0000_0000;
		lat = '{default: 16'h0000};
		ena = '{default: 16'h0000};
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs();
		t_pins();
		t_sum();
		t_hold();
		end_sim();
	end
endmodule
